// ==== hdl/iam_top.sv ====
// Indirect address mapper: pointer and bank registers plus access sequencer.
// Assumes the core holds a request one cycle and memories answer as noted on the ports.
`timescale 1ns/10ps
module iam_top
  import iam_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LIN_END = LIN_IMPL_TOP  // Last implemented linear byte
) (
  input  wire logic               CLK_I,        // Core clock, 100 MHz
  input  wire logic               RESETN_I,     // Async reset, active low
  input  wire logic [OFF_W-1:0]   ACC_ADDR_I,   // In-bank offset of the core access
  input  wire logic               ACC_RD_I,     // Read request pulse
  input  wire logic               ACC_WR_I,     // Write request pulse
  input  wire logic [7:0]         ACC_WDATA_I,  // Write data
  output logic                    ACC_BUSY_O,   // Sequencer busy, requests ignored
  output logic                    ACC_DONE_O,   // One-cycle completion pulse
  output logic      [7:0]         ACC_RDATA_O,  // Read data, valid with done
  output logic      [DMEM_AW-1:0] MEM_ADDR_O,   // Data memory absolute address
  output logic                    MEM_RD_O,     // Data memory read strobe
  output logic                    MEM_WR_O,     // Data memory write strobe
  output logic      [7:0]         MEM_WDATA_O,  // Data memory write data
  input  wire logic [7:0]         MEM_RDATA_I,  // Data memory read data, same cycle
  output logic      [EE_AW-1:0]   EE_ADDR_O,    // EEPROM byte address
  output logic                    EE_RD_O,      // EEPROM read strobe
  input  wire logic [7:0]         EE_RDATA_I,   // EEPROM data, cycle after strobe
  output logic      [PF_AW-1:0]   PF_ADDR_O,    // Flash word address
  output logic                    PF_RD_O,      // Flash read strobe
  input  wire logic [PF_DW-1:0]   PF_RDATA_I    // Flash word, cycle after strobe
);

  // Refuse a linear end that leaves the linear window, at elaboration
  if (LIN_END < LIN_BASE || LIN_END > LIN_TOP) begin : g_bad_lin_end
    $error("LIN_END outside linear window");
  end

  // Reset release synchroniser
  logic rst_meta_reg;              // First stage, read only by second
  logic rst_sync_reg;              // Released reset used by the block
  logic rst_n;                     // Internal active-low reset

  // Architectural registers
  logic [ADDR_W-1:0] ptr0_reg;     // pointer_zero
  logic [ADDR_W-1:0] ptr1_reg;     // pointer_one
  logic [BANK_W-1:0] bank_reg;     // bank_select

  // Sequencer
  iam_state_t        state_reg;    // Current state
  iam_state_t        state_next;   // Next state
  iam_kind_t         kind_reg;     // Landing kind of the held access
  iam_kind_t         kind_next;    // Landing kind being decoded
  logic [DMEM_AW-1:0] taddr_reg;   // Held absolute address
  logic [DMEM_AW-1:0] taddr_next;  // Absolute address being decoded
  logic [PF_AW-1:0]  nvaddr_reg;   // Held nonvolatile address
  logic              rd_reg;       // Held access is a read
  logic              wr_reg;       // Held access is a write
  logic [7:0]        wdata_reg;    // Held write data
  logic [7:0]        rdata_reg;    // Read result
  logic              done_reg;     // Completion pulse

  // Decode helpers
  logic              accept;       // Request taken this cycle
  logic              is_ind;       // Offset names an indirect port
  logic [ADDR_W-1:0] sel_ptr;      // Pointer tied to the port used
  iam_kind_t         dec_kind;     // Decoder region
  logic [DMEM_AW-1:0] dec_addr;    // Decoder banked address
  logic [PF_AW-1:0]  dec_nv;       // Decoder nonvolatile address
  logic [7:0]        local_rdata;  // Local register read value
  logic [7:0]        rdata_next;   // Value captured at end of access

  assign rst_n = rst_sync_reg;

  // Two flops so release is clean against CLK_I
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // One decoder serves both ports since only one access runs at a time
  assign sel_ptr = ACC_ADDR_I[0] ? ptr1_reg : ptr0_reg;

  iam_decode #(
    .LIN_END     (LIN_END)
  ) u_decode (
    .ptr_i       (sel_ptr),
    .kind_o      (dec_kind),
    .bank_addr_o (dec_addr),
    .nv_addr_o   (dec_nv)
  );

  assign accept = (state_reg == ST_IDLE) && (ACC_RD_I || ACC_WR_I);
  // Only the in-bank offset matters, so every bank mirrors the ports
  assign is_ind = (ACC_ADDR_I == OFF_IND0) || (ACC_ADDR_I == OFF_IND1);

  // Final landing of a request: direct or via pointer, then core offsets
  always_comb begin
    kind_next  = K_MEM;
    taddr_next = {bank_reg, ACC_ADDR_I};
    if (is_ind) begin
      kind_next  = dec_kind;
      taddr_next = dec_addr;
    end
    if (kind_next == K_MEM) begin
      // Core registers sit at the same offsets in every bank
      if (taddr_next[OFF_W-1:0] == OFF_IND0 || taddr_next[OFF_W-1:0] == OFF_IND1) begin
        kind_next = K_ZERO;
      end else if (taddr_next[OFF_W-1:0] >= OFF_P0L && taddr_next[OFF_W-1:0] <= OFF_BANK) begin
        kind_next = K_LOCAL;
      end
    end
  end

  // Local register read mux; unused bank bits read zero
  always_comb begin
    case (taddr_reg[OFF_W-1:0])
      OFF_P0L:  local_rdata = ptr0_reg[7:0];
      OFF_P0H:  local_rdata = ptr0_reg[15:8];
      OFF_P1L:  local_rdata = ptr1_reg[7:0];
      OFF_P1H:  local_rdata = ptr1_reg[15:8];
      OFF_BANK: local_rdata = {2'b00, bank_reg};
      default:  local_rdata = ZERO_BYTE;
    endcase
  end

  // Pointer and bank registers, written only in the access cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ptr0_reg <= PTR_RST;
      ptr1_reg <= PTR_RST;
      bank_reg <= BANK_RST;
    end else if (state_reg == ST_ACCESS && kind_reg == K_LOCAL && wr_reg) begin
      case (taddr_reg[OFF_W-1:0])
        OFF_P0L:  ptr0_reg[7:0]  <= wdata_reg;
        OFF_P0H:  ptr0_reg[15:8] <= wdata_reg;
        OFF_P1L:  ptr1_reg[7:0]  <= wdata_reg;
        OFF_P1H:  ptr1_reg[15:8] <= wdata_reg;
        OFF_BANK: bank_reg       <= wdata_reg[BANK_W-1:0];
        default:  bank_reg       <= bank_reg;
      endcase
    end
  end

  // Held request, captured on accept
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg   <= K_ZERO;
      taddr_reg  <= '0;
      nvaddr_reg <= '0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      wdata_reg  <= ZERO_BYTE;
    end else if (accept) begin
      kind_reg   <= kind_next;
      taddr_reg  <= taddr_next;
      nvaddr_reg <= dec_nv;
      rd_reg     <= ACC_RD_I;
      wr_reg     <= ACC_WR_I;
      wdata_reg  <= ACC_WDATA_I;
    end
  end

  // Next state: flash accesses and EEPROM reads spend one more cycle
  always_comb begin
    case (state_reg)
      ST_IDLE:   state_next = accept ? ST_ACCESS : ST_IDLE;
      ST_ACCESS: begin
        if (kind_reg == K_PF || (kind_reg == K_EE && rd_reg)) begin
          state_next = ST_NVWAIT;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_NVWAIT: state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read value picked from the landing place
  always_comb begin
    case (kind_reg)
      K_MEM:   rdata_next = MEM_RDATA_I;
      K_LOCAL: rdata_next = local_rdata;
      K_EE:    rdata_next = EE_RDATA_I;
      K_PF:    rdata_next = PF_RDATA_I[7:0];
      default: rdata_next = ZERO_BYTE;
    endcase
  end

  // Result and done pulse when the sequencer returns to idle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ZERO_BYTE;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
      if ((state_reg != ST_IDLE) && (state_next == ST_IDLE) && rd_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Strobes only in the access cycle; nonvolatile writes get none
  assign MEM_RD_O    = (state_reg == ST_ACCESS) && (kind_reg == K_MEM) && rd_reg;
  assign MEM_WR_O    = (state_reg == ST_ACCESS) && (kind_reg == K_MEM) && wr_reg;
  assign EE_RD_O     = (state_reg == ST_ACCESS) && (kind_reg == K_EE) && rd_reg;
  assign PF_RD_O     = (state_reg == ST_ACCESS) && (kind_reg == K_PF) && rd_reg;
  assign MEM_ADDR_O  = taddr_reg;
  assign MEM_WDATA_O = wdata_reg;
  assign EE_ADDR_O   = nvaddr_reg[EE_AW-1:0];
  assign PF_ADDR_O   = nvaddr_reg;
  assign ACC_BUSY_O  = (state_reg != ST_IDLE);
  assign ACC_DONE_O  = done_reg;
  assign ACC_RDATA_O = rdata_reg;

  // Checks on the mapping and its timing
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_ind_rd;
    accept && is_ind && ACC_RD_I;
  endsequence

  sequence s_nv_tail;
    !ACC_DONE_O ##1 ACC_DONE_O;
  endsequence

  AST_SELF_ZERO: assert property (
    s_ind_rd and (dec_kind == K_MEM && dec_addr[OFF_W-1:0] <= OFF_IND1)
      |-> ##2 ACC_DONE_O && ACC_RDATA_O == ZERO_BYTE)
    else $error("self pointer read not zero");

  AST_SELF_NOWR: assert property (
    accept && is_ind && ACC_WR_I && kind_next == K_ZERO |-> ##1 !MEM_WR_O [*2])
    else $error("write through self pointer reached memory");

  AST_EE_LAT: assert property (
    s_ind_rd and (dec_kind == K_EE) |-> ##1 EE_RD_O ##1 s_nv_tail)
    else $error("EEPROM read latency wrong");

  AST_EE_ADDR: assert property (
    s_ind_rd and (dec_kind == K_EE) |-> ##1 EE_ADDR_O == $past(sel_ptr[7:0]))
    else $error("EEPROM address wrong");

  AST_PF_LAT: assert property (
    accept && is_ind && dec_kind == K_PF |-> ##1 ACC_BUSY_O [*2] ##1 ACC_DONE_O)
    else $error("flash access latency wrong");

  AST_PF_NOWR: assert property (
    kind_reg == K_PF || kind_reg == K_EE |-> !MEM_WR_O)
    else $error("nonvolatile write reached memory");

  AST_MEM_LAT: assert property (
    accept && kind_next == K_MEM |-> ##1 (MEM_RD_O || MEM_WR_O) ##1 ACC_DONE_O && !ACC_BUSY_O)
    else $error("data memory access timing wrong");

  AST_DIRECT: assert property (
    accept && !is_ind && kind_next == K_MEM |-> ##1 MEM_ADDR_O == {$past(bank_reg), $past(ACC_ADDR_I)})
    else $error("direct address wrong");

  AST_LIN_GPR: assert property (
    dec_kind == K_MEM && sel_ptr >= LIN_BASE && !sel_ptr[ADDR_W-1] |->
      dec_addr[OFF_W-1:0] >= GPR_BASE && dec_addr[OFF_W-1:0] < OFF_W'(GPR_BASE + GPR_SIZE))
    else $error("linear address left GENERAL_RAM block");

  AST_PTR_WR: assert property (
    state_reg == ST_ACCESS && kind_reg == K_LOCAL && wr_reg && taddr_reg[OFF_W-1:0] == OFF_P0H
      |=> ptr0_reg[15:8] == $past(wdata_reg))
    else $error("pointer high byte not written");

endmodule

// ==== include/iam_pkg.sv ====
// Constants and types of the indirect address mapper.
// Assumes an 8-bit data path and a 13-bit absolute data memory address.
package iam_pkg;

  localparam int ADDR_W  = 16;               // Pointer width
  localparam int DMEM_AW = 13;               // Absolute banked address width
  localparam int OFF_W   = 7;                // In-bank offset width
  localparam int BANK_W  = 6;                // Bank select field width
  localparam int EE_AW   = 8;                // EEPROM byte address width
  localparam int PF_AW   = 15;               // Program flash word address width
  localparam int PF_DW   = 14;               // Program flash word width

  // Core register offsets, repeated in every bank
  localparam logic [OFF_W-1:0] OFF_IND0 = 7'h00;
  localparam logic [OFF_W-1:0] OFF_IND1 = 7'h01;
  localparam logic [OFF_W-1:0] OFF_P0L  = 7'h04;
  localparam logic [OFF_W-1:0] OFF_P0H  = 7'h05;
  localparam logic [OFF_W-1:0] OFF_P1L  = 7'h06;
  localparam logic [OFF_W-1:0] OFF_P1H  = 7'h07;
  localparam logic [OFF_W-1:0] OFF_BANK = 7'h08;

  // Pointer space regions
  localparam logic [ADDR_W-1:0] BANKED_TOP   = 16'h1FFF;
  localparam logic [ADDR_W-1:0] LIN_BASE     = 16'h2000;
  localparam logic [ADDR_W-1:0] LIN_TOP      = 16'h2FEF;
  localparam logic [ADDR_W-1:0] LIN_IMPL_TOP = 16'h21EF;
  localparam logic [7:0]        EE_HIGH      = 8'h70;
  localparam logic [OFF_W-1:0]  GPR_BASE     = 7'h20;
  localparam logic [OFF_W-1:0]  GPR_SIZE     = 7'h50;

  // Reset and read-back values
  localparam logic [ADDR_W-1:0] PTR_RST   = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST  = 6'h00;
  localparam logic [7:0]        ZERO_BYTE = 8'h00;

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACCESS = 3'b010,
    ST_NVWAIT = 3'b100
  } iam_state_t;

  // Where an access finally lands
  typedef enum logic [4:0] {
    K_MEM   = 5'b00001,
    K_LOCAL = 5'b00010,
    K_EE    = 5'b00100,
    K_PF    = 5'b01000,
    K_ZERO  = 5'b10000
  } iam_kind_t;

endpackage

// ==== hdl/iam_decode.sv ====
// Pointer decoder: splits a 16-bit pointer into its region and target address.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/10ps
module iam_decode
  import iam_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LIN_END = LIN_IMPL_TOP  // Last implemented linear byte
) (
  input  wire logic [ADDR_W-1:0]  ptr_i,       // Pointer value
  output iam_kind_t               kind_o,      // Region kind
  output logic      [DMEM_AW-1:0] bank_addr_o, // Absolute banked address
  output logic      [PF_AW-1:0]   nv_addr_o    // EEPROM or flash address
);

  logic [11:0]        lin_off;   // Byte offset inside the linear window
  logic [BANK_W-1:0]  lin_bank;  // Bank reached by the linear offset
  logic [OFF_W-1:0]   lin_idx;   // Byte inside that bank's GENERAL_RAM block

  // Linear view: 80-byte blocks chained bank after bank
  always_comb begin
    lin_off  = 12'(ptr_i - LIN_BASE);
    lin_bank = BANK_W'(lin_off / 12'(GPR_SIZE));
    lin_idx  = OFF_W'(lin_off % 12'(GPR_SIZE));
  end

  // Region select; anything outside the known windows reads zero
  always_comb begin
    kind_o      = K_ZERO;
    bank_addr_o = ptr_i[DMEM_AW-1:0];
    nv_addr_o   = ptr_i[PF_AW-1:0];
    if (ptr_i[ADDR_W-1]) begin
      kind_o = K_PF;
    end else if (ptr_i <= BANKED_TOP) begin
      kind_o = K_MEM;
    end else if (ptr_i >= LIN_BASE && ptr_i <= LIN_TOP) begin
      // Common RAM never shows here: offsets stop at 0x6F
      bank_addr_o = {lin_bank, OFF_W'(GPR_BASE + lin_idx)};
      kind_o      = (ptr_i <= LIN_END) ? K_MEM : K_ZERO;
    end else if (ptr_i[15:8] == EE_HIGH) begin
      kind_o    = K_EE;
      nv_addr_o = {7'h00, ptr_i[7:0]};
    end else begin
      kind_o = K_ZERO;
    end
  end

endmodule

// ==== test/iam_mem_model.sv ====
// Behavioural far side of the mapper: data RAM, data EEPROM and program flash.
// Assumes the strobe timing of iam_top: RAM answers in the strobe cycle, NVM one cycle later.
`timescale 1ns/10ps
module iam_mem_model
  import iam_pkg::*;
(
  input  wire logic               clk_i,        // Core clock
  input  wire logic [DMEM_AW-1:0] mem_addr_i,   // Absolute RAM address
  input  wire logic               mem_rd_i,     // RAM read strobe
  input  wire logic               mem_wr_i,     // RAM write strobe
  input  wire logic [7:0]         mem_wdata_i,  // RAM write data
  output logic      [7:0]         mem_rdata_o,  // RAM read data
  input  wire logic [EE_AW-1:0]   ee_addr_i,    // EEPROM byte address
  input  wire logic               ee_rd_i,      // EEPROM read strobe
  output logic      [7:0]         ee_rdata_o,   // EEPROM data
  input  wire logic [PF_AW-1:0]   pf_addr_i,    // Flash word address
  input  wire logic               pf_rd_i,      // Flash read strobe
  output logic      [PF_DW-1:0]   pf_rdata_o    // Flash word
);
  logic [7:0]       dmem [2**DMEM_AW];  // RAM contents, address-derived pattern
  logic [7:0]       ee_q;               // Last EEPROM byte fetched
  logic             ee_v;               // EEPROM data valid this cycle
  logic [PF_DW-1:0] pf_q;               // Last flash word fetched
  logic             pf_v;               // Flash data valid this cycle

  // Seed RAM so that every address reads a distinct-looking byte
  initial begin
    for (int i = 0; i < 2**DMEM_AW; i++) dmem[i] = 8'(i) ^ 8'(i >> 8);
  end

  // RAM writes land on the edge that ends the strobe cycle
  always @(posedge clk_i) begin
    if (mem_wr_i) dmem[mem_addr_i] <= mem_wdata_i;
  end

  // NVM fetch: valid only for one cycle, then the data lines invert so stale data never matches
  always @(posedge clk_i) begin
    ee_v <= ee_rd_i;
    pf_v <= pf_rd_i;
    if (ee_rd_i) ee_q <= ~ee_addr_i;
    if (pf_rd_i) pf_q <= {6'h2A, pf_addr_i[7:0] ^ {1'b0, pf_addr_i[14:8]}};
  end

  // Outputs outside their answer window carry the inverse of the last value
  assign mem_rdata_o = mem_rd_i ? dmem[mem_addr_i] : ~dmem[mem_addr_i];
  assign ee_rdata_o  = ee_v ? ee_q : ~ee_q;
  assign pf_rdata_o  = pf_v ? pf_q : ~pf_q;
endmodule

// ==== test/indirect_address_mapper_tb_top.sv ====
// Self-checking bench for the indirect address mapper and its memory model.
// Assumes one 100 MHz clock; pointer reads go through indirect port 0 or 1.
`timescale 1ns/10ps
module indirect_address_mapper_tb_top
  import iam_pkg::*;
;
  typedef struct packed {
    logic [15:0] ptr;   // Pointer value
    logic [2:0]  kind;  // 0 ram, 1 eeprom, 2 flash, 3 zero, 4 local reg
    logic [15:0] tgt;   // Expected target address, or local value
  } iam_row_t;
  localparam int       WATCHDOG_CYCLES = 4000;  // Whole run needs well under 1000 cycles
  localparam iam_row_t ROWS [17] = '{
    '{16'h0123, 3'd0, 16'h0123}, '{16'h1FFF, 3'd0, 16'h1FFF}, '{16'h0070, 3'd0, 16'h0070},
    '{16'h2000, 3'd0, 16'h0020}, '{16'h204F, 3'd0, 16'h006F}, '{16'h2050, 3'd0, 16'h00A0},
    '{16'h21EF, 3'd0, 16'h032F}, '{16'h21F0, 3'd3, 16'h0000}, '{16'h2FEF, 3'd3, 16'h0000},
    '{16'h3000, 3'd3, 16'h0000}, '{16'h7000, 3'd1, 16'h0000}, '{16'h70FF, 3'd1, 16'h00FF},
    '{16'h7100, 3'd3, 16'h0000}, '{16'h8000, 3'd2, 16'h0000}, '{16'hFFFF, 3'd2, 16'h7FFF},
    '{16'h0080, 3'd3, 16'h0000}, '{16'h0F84, 3'd4, 16'h0084}};

  logic               CLK_I, RESETN_I, ACC_RD_I, ACC_WR_I, ACC_BUSY_O, ACC_DONE_O;
  logic               MEM_RD_O, MEM_WR_O, EE_RD_O, PF_RD_O;
  logic [OFF_W-1:0]   ACC_ADDR_I;
  logic [7:0]         ACC_WDATA_I, ACC_RDATA_O, MEM_WDATA_O, MEM_RDATA_I, EE_RDATA_I;
  logic [DMEM_AW-1:0] MEM_ADDR_O, last_mem;  // last_mem: address of latest RAM strobe
  logic [EE_AW-1:0]   EE_ADDR_O;
  logic [PF_AW-1:0]   PF_ADDR_O;
  logic [15:0]        last_nv;               // Address of latest NVM strobe
  logic [PF_DW-1:0]   PF_RDATA_I;
  int                 mismatches, num_checks, n_mem, n_wr, n_ee, n_pf, d_mem, d_wr, d_ee, d_pf, base;

  iam_top u_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ACC_ADDR_I(ACC_ADDR_I), .ACC_RD_I(ACC_RD_I),
    .ACC_WR_I(ACC_WR_I), .ACC_WDATA_I(ACC_WDATA_I), .ACC_BUSY_O(ACC_BUSY_O), .ACC_DONE_O(ACC_DONE_O),
    .ACC_RDATA_O(ACC_RDATA_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I), .EE_ADDR_O(EE_ADDR_O), .EE_RD_O(EE_RD_O),
    .EE_RDATA_I(EE_RDATA_I), .PF_ADDR_O(PF_ADDR_O), .PF_RD_O(PF_RD_O), .PF_RDATA_I(PF_RDATA_I));
  iam_mem_model u_mem (.clk_i(CLK_I), .mem_addr_i(MEM_ADDR_O), .mem_rd_i(MEM_RD_O), .mem_wr_i(MEM_WR_O),
    .mem_wdata_i(MEM_WDATA_O), .mem_rdata_o(MEM_RDATA_I), .ee_addr_i(EE_ADDR_O), .ee_rd_i(EE_RD_O),
    .ee_rdata_o(EE_RDATA_I), .pf_addr_i(PF_ADDR_O), .pf_rd_i(PF_RD_O), .pf_rdata_o(PF_RDATA_I));

  // 100 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // Strobe monitor: counts every strobe and keeps the address it carried
  always @(posedge CLK_I) begin
    if (MEM_RD_O | MEM_WR_O) begin
      n_mem++;
      last_mem = MEM_ADDR_O;
    end
    if (MEM_WR_O) n_wr++;
    if (EE_RD_O) begin
      n_ee++;
      last_nv = 16'(EE_ADDR_O);
    end
    if (PF_RD_O) begin
      n_pf++;
      last_nv = 16'(PF_ADDR_O);
    end
  end

  // Hang guard, sized from the expected run length
  initial begin
    repeat (WATCHDOG_CYCLES) @(posedge CLK_I);
    mismatches++;
    tally_and_finish();
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One core access, entered just after an edge; returns edges from accept to done
  task automatic acc(input logic wr, input logic [6:0] off, input logic [7:0] wd, output int lat);
    int s_mem, s_wr, s_ee, s_pf;
    s_mem = n_mem; s_wr = n_wr; s_ee = n_ee; s_pf = n_pf;
    ACC_RD_I = ~wr; ACC_WR_I = wr; ACC_ADDR_I = off; ACC_WDATA_I = wd;
    @(posedge CLK_I);
    #1;
    check("acc_busy", {15'h0, ACC_BUSY_O}, 16'h0001);
    ACC_RD_I = 1'b0; ACC_WR_I = 1'b0;
    lat = 0;
    // Returning in the done cycle lets the next request go out back to back
    while (ACC_DONE_O !== 1'b1 && lat < 20) begin
      @(posedge CLK_I);
      #1;
      lat++;
    end
    d_mem = n_mem - s_mem; d_wr = n_wr - s_wr; d_ee = n_ee - s_ee; d_pf = n_pf - s_pf;
  endtask

  task automatic rd(input logic [6:0] off, output logic [7:0] d, output int lat);
    acc(1'b0, off, 8'h00, lat);
    d = ACC_RDATA_O;
  endtask

  // Loads pointer sel with p, low byte then high byte
  task automatic setp(input logic sel, input logic [15:0] p);
    int lat;
    acc(1'b1, 7'h04 + 7'({sel, 1'b0}), p[7:0], lat);
    acc(1'b1, 7'h05 + 7'({sel, 1'b0}), p[15:8], lat);
    base = lat;  // Plain register write sets the ordinary latency
  endtask

  // Write through a pointer into a region that must swallow it
  task automatic drop_wr(input logic [15:0] p, input int extra);
    int lat;
    setp(1'b0, p);
    acc(1'b1, 7'h00, 8'hC9, lat);
    check("drop_strobes", 16'(d_mem + d_ee + d_pf), 16'h0000);
    check("drop_latency", 16'(lat), 16'(base + extra));
  endtask

  function automatic logic [7:0] expd(input iam_row_t r);
    case (r.kind)
      3'd0: return r.tgt[7:0] ^ {3'h0, r.tgt[12:8]};
      3'd1: return ~r.tgt[7:0];
      3'd2: return r.tgt[7:0] ^ {1'b0, r.tgt[14:8]};
      3'd4: return r.tgt[7:0];
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    logic [7:0] d;
    int         lat;
    iam_row_t   r;
    {mismatches, num_checks, n_mem, n_wr, n_ee, n_pf} = '0;
    {ACC_RD_I, ACC_WR_I, ACC_ADDR_I, ACC_WDATA_I} = '0;
    RESETN_I = 1'b0;
    repeat (10) @(posedge CLK_I);
    #1 RESETN_I = 1'b1;
    repeat (3) @(posedge CLK_I);
    #1;
    // Region table through both pointers
    for (int i = 0; i < 17; i++) begin
      r = ROWS[i];
      setp(i[0], r.ptr);
      rd(7'(i[0]), d, lat);
      check("row_rdata", {8'h00, d}, {8'h00, expd(r)});
      check("row_strobes", 16'(d_mem * 4 + d_ee * 2 + d_pf), 16'(4 >> r.kind));
      check("row_latency", 16'(lat), 16'(base + 32'(r.kind == 1 || r.kind == 2)));
      if (r.kind == 0) check("row_ram_addr", {3'h0, last_mem}, r.tgt);
      if (r.kind == 1 || r.kind == 2) check("row_nv_addr", last_nv, r.tgt);
    end
    $display("Test region table done");
    // Indirect write, then read back through the same pointer
    setp(1'b0, 16'h0123);
    acc(1'b1, 7'h00, 8'h5A, lat);
    check("wr_addr", {3'h0, last_mem}, 16'h0123);
    check("wr_count", 16'(d_wr), 16'h0001);
    rd(7'h00, d, lat);
    check("wr_back", {8'h00, d}, 16'h005A);
    // Linear write lands in bank 1, seen again by a direct access
    setp(1'b1, 16'h2050);
    acc(1'b1, 7'h01, 8'h3C, lat);
    check("lin_wr_addr", {3'h0, last_mem}, 16'h00A0);
    acc(1'b1, 7'h08, 8'h01, lat);
    rd(7'h20, d, lat);
    check("direct_rdata", {8'h00, d}, 16'h003C);
    check("direct_addr", {3'h0, last_mem}, 16'h00A0);
    $display("Test indirect writes done");
    // Writes that must be dropped, and contents left untouched
    drop_wr(16'h7005, 0);
    rd(7'h00, d, lat);
    check("ee_kept", {8'h00, d}, 16'h00FA);
    drop_wr(16'h8005, 1);
    rd(7'h00, d, lat);
    check("pf_kept", {8'h00, d}, 16'h0005);
    drop_wr(16'h0001, 0);
    drop_wr(16'h3000, 0);
    $display("Test dropped writes done");
    // Pointer through a high bank onto pointer 0's low byte, then 16-bit read-back
    setp(1'b1, 16'h1F84);
    acc(1'b1, 7'h01, 8'h77, lat);
    rd(7'h04, d, lat);
    check("mirror_reg", {8'h00, d}, 16'h0077);
    setp(1'b1, 16'hA5C3);
    rd(7'h06, d, lat);
    check("ptr1_low", {8'h00, d}, 16'h00C3);
    rd(7'h07, d, lat);
    check("ptr1_high", {8'h00, d}, 16'h00A5);
    // Bank select keeps six bits and forms the upper address bits
    acc(1'b1, 7'h08, 8'hFF, lat);
    rd(7'h08, d, lat);
    check("bank_back", {8'h00, d}, 16'h003F);
    rd(7'h0A, d, lat);
    check("bank_addr", {3'h0, last_mem}, 16'h1F8A);
    check("bank_rdata", {8'h00, d}, 16'h0095);
    // A write offered while a flash read is busy must be ignored
    setp(1'b0, 16'h8005);
    ACC_RD_I = 1'b1; ACC_ADDR_I = 7'h00;
    @(posedge CLK_I);
    #1 ACC_RD_I = 1'b0; ACC_WR_I = 1'b1; ACC_ADDR_I = 7'h08; ACC_WDATA_I = 8'h11;
    @(posedge CLK_I);
    #1 ACC_WR_I = 1'b0;
    repeat (2) @(posedge CLK_I);
    #1;
    check("busy_pf_rdata", {8'h00, ACC_RDATA_O}, 16'h0005);
    rd(7'h08, d, lat);
    check("busy_ignored", {8'h00, d}, 16'h003F);
    $display("Test registers done");
    // Second reset in mid-run clears pointers and bank
    RESETN_I = 1'b0;
    repeat (2) @(posedge CLK_I);
    #1 RESETN_I = 1'b1;
    repeat (3) @(posedge CLK_I);
    #1;
    for (int k = 4; k < 9; k++) begin
      rd(7'(k), d, lat);
      check("reset_reg", {8'h00, d}, 16'h0000);
    end
    rd(7'h00, d, lat);
    check("reset_ind", {8'h00, d}, 16'h0000);
    $display("Test reset done");
    tally_and_finish();
  end
endmodule
